//--- ibl_top.sv
// instrument bus line logic: talker, listener and controller roles
// Contract
// - only one controller in charge at once
// - controller in charge may pass control
// - only system controller takes control itself
// - sixteen lines: eight data, three, five
// - attention marks command versus data bytes
// - seven bit code, eighth bit parity/ignored
// - every byte uses interlocked three-wire handshake
// - ready line driven by all/addressed listeners
// - accepted line driven by all/addressed listeners
// - source raises valid only on stable data
// - controller asserts attention for commands only; code also asserts it while ctrl_atn is set and for parallel poll
// - system controller clears bus, takes control
// - system controller drives remote enable line
// - any device may request service anytime
// - talker marks last byte with end
// - attention plus end requests parallel poll
// - all lines low-true, logic inverted inside
// - controller addresses talker, listeners before data
`timescale 1ns/1ns
module ibl_top #(
    parameter int IFC_CYC = ibl_pkg::IFC_CYC_DEF
) (
    input  logic               clk,
    input  logic               nrst,
    input  ibl_pkg::ibl_bus_t  bus_i,
    output ibl_pkg::ibl_bus_t  bus_o,
    output ibl_pkg::ibl_bus_t  bus_oe,
    input  logic               sys_strap,
    input  logic [4:0]         my_addr,
    input  logic               par_en,
    input  logic               ctrl_atn,
    input  logic               ifc_req,
    input  logic               ren_req,
    input  logic               srq_req,
    input  logic               pp_req,
    input  logic               pp_en,
    input  logic [2:0]         pp_line,
    input  logic               pp_resp,
    input  logic               tx_valid,
    input  ibl_pkg::ibl_byte_t tx_byte,
    output logic               tx_ready,
    input  logic               rx_ready,
    output logic               rx_valid,
    output ibl_pkg::ibl_byte_t rx_byte,
    output logic               tx_done,
    output logic               pp_done,
    output logic [7:0]         pp_result,
    output logic               cic,
    output logic               talker,
    output logic               listener,
    output logic               remote,
    output logic               srq_seen
);
    import ibl_pkg::*;

    // line levels turned into true flags
    logic atn_t, eoi_t, ifc_t, nrfd_t, ndac_t, dav_t;
    assign atn_t  = asserted(bus_i.atn);
    assign eoi_t  = asserted(bus_i.eoi);
    assign ifc_t  = asserted(bus_i.ifc);
    assign nrfd_t = asserted(bus_i.nrfd);
    assign ndac_t = asserted(bus_i.ndac);
    assign dav_t  = asserted(bus_i.dav);

    ibl_src_st_t      src_st_r;
    ibl_byte_t        cur_r;
    logic [CNT_W-1:0] src_cnt_r, pp_cnt_r, ifc_cnt_r;
    logic [7:0]       data_oe_r, pp_vec;
    logic             dav_oe_r, atn_oe_r, eoi_oe_r, ifc_oe_r;
    logic             ren_oe_r, srq_oe_r, sys_r, strap_done_r;
    logic             pp_act_r, tct_pend_r, pass_pend_r;
    logic             acc_en, acc_nrfd, acc_ndac, accept, ok_now;
    logic             cmd_evt;
    ibl_dec_t         dec;
    ibl_bus_t         bus_o_r;

    // open-drain pins: the level is always low, enables do the work
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            bus_o_r <= '0;
        else
            bus_o_r <= '0;
    end
    assign bus_o = bus_o_r;

    // sixteen enables, each from a flop
    assign bus_oe = '{dio: data_oe_r, dav: dav_oe_r, nrfd: acc_nrfd,
                      ndac: acc_ndac, atn: atn_oe_r, ifc: ifc_oe_r,
                      ren: ren_oe_r, srq: srq_oe_r, eoi: eoi_oe_r};

    // strap sampled once after reset release, never under reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sys_r        <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            sys_r        <= sys_strap;
            strap_done_r <= 1'b1;
        end
    end

    // commands need control; data needs talker role and attention off
    // data only from addressed talker
    assign ok_now = tx_byte.cmd ? cic : (talker && !atn_t);
    assign accept = tx_valid && tx_ready && ok_now
                    && src_st_r == SRC_IDLE && !pp_act_r;

    // source handshake; settle wait covers the data register lag
    // interlocked source sequence
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_st_r  <= SRC_IDLE;
            cur_r     <= '0;
            src_cnt_r <= '0;
            dav_oe_r  <= 1'b0;
            tx_ready  <= 1'b0;
            tx_done   <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            unique case (src_st_r)
                SRC_IDLE: begin
                    tx_ready <= !accept && !pp_act_r && (cic || talker);
                    if (accept) begin
                        cur_r <= tx_byte;
                        if (tx_byte.cmd && par_en)
                            cur_r.data[PAR_BIT] <=
                                ~^(tx_byte.data & CODE7_MASK);
                        src_cnt_r <= CNT_W'(SETTLE_CYC - 1);
                        src_st_r  <= SRC_SETTLE;
                    end
                end
                // all ready and previous byte taken
                SRC_SETTLE: begin
                    if (src_cnt_r != '0)
                        src_cnt_r <= src_cnt_r - 1'b1;
                    else if (!nrfd_t && ndac_t) begin
                        dav_oe_r <= 1'b1;
                        src_st_r <= SRC_DAV;
                    end
                end
                SRC_DAV: begin
                    if (!ndac_t) begin
                        dav_oe_r <= 1'b0;
                        src_st_r <= SRC_REL;
                    end
                end
                SRC_REL: begin
                    tx_done  <= 1'b1;
                    src_st_r <= SRC_IDLE;
                end
            endcase
        end
    end

    // parallel poll answer: one configured line, only while polled
    assign pp_vec = (pp_en && pp_resp && !cic && atn_t && eoi_t)
                    ? (ONE_HOT0 << pp_line) : '0;

    // data, attention and end drive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_oe_r <= '0;
            atn_oe_r  <= 1'b0;
            eoi_oe_r  <= 1'b0;
        end else begin
            data_oe_r <= (src_st_r != SRC_IDLE) ? cur_r.data : pp_vec;
            atn_oe_r  <= cic && (ctrl_atn || pp_act_r ||
                         (src_st_r != SRC_IDLE && cur_r.cmd));
            eoi_oe_r  <= pp_act_r || (src_st_r != SRC_IDLE &&
                         !cur_r.cmd && cur_r.last);
        end
    end

    // poll: attention and end, then read lines
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pp_act_r  <= 1'b0;
            pp_cnt_r  <= '0;
            pp_done   <= 1'b0;
            pp_result <= '0;
        end else begin
            pp_done <= 1'b0;
            if (!pp_act_r) begin
                if (pp_req && cic && src_st_r == SRC_IDLE) begin
                    pp_act_r <= 1'b1;
                    pp_cnt_r <= CNT_W'(PP_CYC - 1);
                end
            end else if (pp_cnt_r != '0) begin
                pp_cnt_r <= pp_cnt_r - 1'b1;
            end else begin
                pp_act_r  <= 1'b0;
                pp_done   <= 1'b1;
                pp_result <= ~bus_i.dio;
            end
        end
    end

    // clear pulse only from system controller
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ifc_oe_r  <= 1'b0;
            ifc_cnt_r <= '0;
        end else if (ifc_oe_r) begin
            if (ifc_cnt_r != '0)
                ifc_cnt_r <= ifc_cnt_r - 1'b1;
            else
                ifc_oe_r <= 1'b0;
        end else if (ifc_req && sys_r) begin
            ifc_oe_r  <= 1'b1;
            ifc_cnt_r <= CNT_W'(IFC_CYC - 1);
        end
    end

    // remote enable; service request any time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ren_oe_r <= 1'b0;
            srq_oe_r <= 1'b0;
            remote   <= 1'b0;
            srq_seen <= 1'b0;
        end else begin
            ren_oe_r <= sys_r && ren_req;
            srq_oe_r <= srq_req;
            remote   <= asserted(bus_i.ren);
            srq_seen <= asserted(bus_i.srq);
        end
    end

    // commands we take or send both steer our addressing
    assign cmd_evt = (rx_valid && rx_byte.cmd) || (tx_done && cur_r.cmd);
    assign dec = decode((rx_valid && rx_byte.cmd) ? rx_byte.data
                        : cur_r.data, my_addr);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            talker   <= 1'b0;
            listener <= 1'b0;
        end else if (ifc_t) begin
            talker   <= 1'b0;
            listener <= 1'b0;
        end else if (cmd_evt) begin
            unique case (dec)
                DEC_MLA: listener <= 1'b1;
                DEC_UNL: listener <= 1'b0;
                DEC_MTA: talker   <= 1'b1;
                DEC_OTA, DEC_UNT: talker <= 1'b0;
                DEC_NONE, DEC_TCT: ;
            endcase
        end
    end

    // control ownership: the clear line wins over any pass in flight
    // single controller in charge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cic         <= 1'b0;
            tct_pend_r  <= 1'b0;
            pass_pend_r <= 1'b0;
        end else if (ifc_t) begin
            // clear makes the driver in charge
            cic         <= ifc_oe_r;
            tct_pend_r  <= 1'b0;
            pass_pend_r <= 1'b0;
        end else begin
            if (tx_done && cur_r.cmd && cic && dec == DEC_TCT)
                pass_pend_r <= 1'b1;
            else if (pass_pend_r && !ctrl_atn) begin
                cic         <= 1'b0;
                pass_pend_r <= 1'b0;
            end
            // non-system controller waits to be passed control
            if (rx_valid && rx_byte.cmd && dec == DEC_TCT && talker)
                tct_pend_r <= 1'b1;
            else if (tct_pend_r && !atn_t) begin
                cic        <= 1'b1;
                tct_pend_r <= 1'b0;
            end
        end
    end

    assign acc_en = src_st_r == SRC_IDLE && !ifc_t &&
                    ((atn_t && !cic) || (!atn_t && listener));

    ibl_acc u_acc (
        .clk      (clk),
        .nrst     (nrst),
        .en       (acc_en),
        .ready    (atn_t || rx_ready),
        .dav      (dav_t),
        .atn      (atn_t),
        .eoi      (eoi_t),
        .dio      (~bus_i.dio),
        .nrfd_oe  (acc_nrfd),
        .ndac_oe  (acc_ndac),
        .rx_valid (rx_valid),
        .rx_byte  (rx_byte)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_byte_up;
        src_st_r == SRC_SETTLE && src_cnt_r == '0 && !nrfd_t && ndac_t;
    endsequence

    a_dav_after_rdy: assert property (s_byte_up |=> dav_oe_r)
        else $error("valid not raised when all ready");
    a_dav_cause: assert property ($rose(dav_oe_r) |->
        $past(!nrfd_t && ndac_t))
        else $error("valid raised while a receiver not ready");
    a_dav_drop: assert property ($fell(dav_oe_r) |-> $past(!ndac_t))
        else $error("valid dropped before all accepted");
    a_data_stable: assert property (dav_oe_r |-> $stable(data_oe_r) &&
        data_oe_r == cur_r.data)
        else $error("data changed while valid");
    a_atn_cmd: assert property (dav_oe_r && cur_r.cmd |-> atn_oe_r)
        else $error("command byte without attention");
    a_eoi_last: assert property (dav_oe_r && !cur_r.cmd |->
        eoi_oe_r == cur_r.last)
        else $error("end line does not match last flag");
    a_ifc_sys: assert property (ifc_oe_r || ren_oe_r |-> sys_r)
        else $error("clear or remote line driven by non system unit");
    a_ifc_hold: assert property ($rose(ifc_oe_r) |-> ifc_oe_r[*8])
        else $error("clear pulse too short");
    a_cic_lost: assert property (ifc_t && !ifc_oe_r |=> !cic)
        else $error("stayed in charge under a foreign clear");
    a_cic_taken: assert property (ifc_t && ifc_oe_r |=> cic)
        else $error("clear did not make us controller");
    a_pp_time: assert property ($rose(pp_act_r) |=>
        (atn_oe_r && eoi_oe_r) [*2] ##[1:200] pp_done)
        else $error("poll not driven or not finished in time");
endmodule

//--- ibl_pkg.sv
// shared constants, carriers and helpers for the instrument bus line logic
package ibl_pkg;

    // clock and timing
    localparam int CLK_HZ      = 50_000_000;
    localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
    localparam int SETTLE_NS   = 2000;
    localparam int SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PP_NS       = 2000;
    localparam int PP_CYC      = (PP_NS * CLK_MHZ + 999) / 1000;
    localparam int IFC_US      = 100;
    localparam int IFC_CYC_DEF = IFC_US * CLK_MHZ;
    localparam int CNT_W       = 13;

    // command byte coding
    localparam logic [7:0] CODE7_MASK = 8'h7F;
    localparam logic [7:0] GRP_MASK   = 8'h60;
    localparam logic [7:0] ADDR_MASK  = 8'h1F;
    localparam logic [7:0] GRP_LISTEN = 8'h20;
    localparam logic [7:0] GRP_TALK   = 8'h40;
    localparam logic [7:0] CMD_UNL    = 8'h3F;
    localparam logic [7:0] CMD_UNT    = 8'h5F;
    localparam logic [7:0] CMD_TCT    = 8'h09;
    localparam int         PAR_BIT    = 7;
    localparam logic [7:0] ONE_HOT0   = 8'h01;

    // one bus snapshot: 8 data, 3 handshake, 5 management lines
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       atn;
        logic       ifc;
        logic       ren;
        logic       srq;
        logic       eoi;
    } ibl_bus_t;

    // a byte as the user side sees it
    typedef struct packed {
        logic [7:0] data;
        logic       cmd;
        logic       last;
    } ibl_byte_t;

    typedef enum logic [2:0] {
        DEC_NONE, DEC_MLA, DEC_MTA, DEC_OTA, DEC_UNL, DEC_UNT, DEC_TCT
    } ibl_dec_t;

    typedef enum logic [1:0] {
        SRC_IDLE   = 2'b00,
        SRC_SETTLE = 2'b01,
        SRC_DAV    = 2'b11,
        SRC_REL    = 2'b10
    } ibl_src_st_t;

    typedef enum logic [1:0] {
        ACC_NRDY = 2'b00,
        ACC_RDY  = 2'b01,
        ACC_ACPT = 2'b11
    } ibl_acc_st_t;

    // bus lines are low-true
    function automatic logic asserted(input logic lvl);
        return ~lvl;
    endfunction

    // classify a command byte; bit 7 is parity or unused
    function automatic ibl_dec_t decode(input logic [7:0] b,
                                        input logic [4:0] addr);
        logic [7:0] c;
        c = b & CODE7_MASK;
        if (c == CMD_UNL)
            return DEC_UNL;
        if (c == CMD_UNT)
            return DEC_UNT;
        if (c == CMD_TCT)
            return DEC_TCT;
        if ((c & GRP_MASK) == GRP_LISTEN && (c & ADDR_MASK) == {3'h0, addr})
            return DEC_MLA;
        if ((c & GRP_MASK) == GRP_TALK)
            return ((c & ADDR_MASK) == {3'h0, addr}) ? DEC_MTA : DEC_OTA;
        return DEC_NONE;
    endfunction

endpackage

//--- ibl_acc.sv
// acceptor side of the interlocked byte handshake
`timescale 1ns/1ns
module ibl_acc (
    input  logic                clk,
    input  logic                nrst,
    input  logic                en,
    input  logic                ready,
    input  logic                dav,
    input  logic                atn,
    input  logic                eoi,
    input  logic [7:0]          dio,
    output logic                nrfd_oe,
    output logic                ndac_oe,
    output logic                rx_valid,
    output ibl_pkg::ibl_byte_t  rx_byte
);
    import ibl_pkg::*;

    ibl_acc_st_t st_r;

    // handshake state and line drive; a non-taking device lets go
    // ready and accepted line drive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r    <= ACC_NRDY;
            nrfd_oe <= 1'b0;
            ndac_oe <= 1'b0;
        end else if (!en) begin
            st_r    <= ACC_NRDY;
            nrfd_oe <= 1'b0;
            ndac_oe <= 1'b0;
        end else begin
            unique case (st_r)
                ACC_NRDY: begin
                    ndac_oe <= 1'b1;
                    if (ready && !dav) begin
                        nrfd_oe <= 1'b0;
                        st_r    <= ACC_RDY;
                    end else begin
                        nrfd_oe <= 1'b1;
                    end
                end
                ACC_RDY: begin
                    if (dav) begin
                        nrfd_oe <= 1'b1;
                        ndac_oe <= 1'b0;
                        st_r    <= ACC_ACPT;
                    end
                end
                ACC_ACPT: begin
                    if (!dav) begin
                        ndac_oe <= 1'b1;
                        st_r    <= ACC_NRDY;
                    end
                end
                default: st_r <= ACC_NRDY;
            endcase
        end
    end

    // capture byte; atn decides command or data
    // byte kind from attention
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_valid <= 1'b0;
            rx_byte  <= '0;
        end else begin
            rx_valid <= en && st_r == ACC_RDY && dav;
            if (en && st_r == ACC_RDY && dav) begin
                rx_byte.data <= dio;
                rx_byte.cmd  <= atn;
                rx_byte.last <= eoi && !atn;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_accept_pulse: assert property (en && st_r == ACC_RDY && dav |=>
        rx_valid && nrfd_oe && !ndac_oe)
        else $error("byte taken without pulse or line change");
    a_idle_release: assert property (!en |=> !nrfd_oe && !ndac_oe)
        else $error("handshake lines driven while not taking part");
    a_ndac_regrab: assert property (en && st_r == ACC_ACPT && !dav |=>
        ndac_oe)
        else $error("accepted line not reasserted after valid fell");
endmodule

//--- ibl_peer.sv
// far-side instrument model: listener, byte source, poll answer, service
`timescale 1ns/1ns
module ibl_peer (
    input  logic              clk,
    input  ibl_pkg::ibl_bus_t bus,
    output ibl_pkg::ibl_bus_t oe
);
    import ibl_pkg::*;

    // knobs set by the bench
    logic       acc_on = 1'b0;
    logic       pp_on  = 1'b0;
    logic       srq    = 1'b0;
    int         stall  = 5;
    // driven levels, high = pull the line true
    logic       atn    = 1'b0;
    logic       eoi    = 1'b0;
    logic       dav    = 1'b0;
    logic [7:0] dio    = 8'h00;
    logic       nrfd_r = 1'b0;
    logic       ndac_r = 1'b0;
    logic [9:0] got[$];  // accepted bytes: true data, attention, end

    // open drain; the poll answer sits on line 3
    always_comb begin
        oe      = '0;
        oe.dio  = dio | {4'h0, pp_on & ~bus.atn & ~bus.eoi, 3'h0};
        oe.dav  = dav;
        oe.nrfd = nrfd_r;
        oe.ndac = ndac_r;
        oe.atn  = atn;
        oe.eoi  = eoi;
        oe.srq  = srq;
    end

    // listener: late ready, accept, wait for valid to end
    initial forever begin
        @(posedge clk);
        nrfd_r <= acc_on;
        ndac_r <= acc_on;
        if (acc_on) begin
            repeat (stall) @(posedge clk);
            nrfd_r <= 1'b0;
            while (bus.dav && acc_on) @(posedge clk);
            if (!bus.dav) got.push_back({~bus.dio, ~bus.atn, ~bus.eoi});
            nrfd_r <= 1'b1;
            ndac_r <= 1'b0;
            while (!bus.dav && acc_on) @(posedge clk);
        end
    end

    // settle, wait ready, valid until accepted
    task automatic send(input logic [7:0] d, input logic a, input logic e);
        atn <= a;
        eoi <= e;
        dio <= d;
        repeat (SETTLE_CYC) @(posedge clk);
        while (!bus.nrfd) @(posedge clk);
        dav <= 1'b1;
        @(posedge clk);
        while (!bus.ndac) @(posedge clk);
        dav <= 1'b0;
        @(posedge clk);
        dio <= 8'h00;
        eoi <= 1'b0;
    endtask
endmodule

//--- tb_ibl_top.sv
// self-checking bench for the instrument bus line logic
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("mismatch %0t %0h %0h", $time, (a), (b)); end end
module tb_ibl_top;
    import ibl_pkg::*;
    localparam int IFC = 16;
    logic       clk = 1'b0;
    logic       nrst, sys_strap, par_en, ctrl_atn, ifc_req, ren_req;
    logic       srq_req, pp_req, pp_en, pp_resp, tx_valid, rx_ready;
    logic       tx_ready, rx_valid, tx_done, pp_done, cic, talker;
    logic       listener, srq_seen, remote;
    logic [4:0] my_addr;
    logic [2:0] pp_line;
    logic [7:0] pp_result;
    ibl_byte_t  tx_byte, rx_byte;
    ibl_bus_t   d_o, d_oe, p_oe, bus_w, prev;
    ibl_byte_t  rxq[$];
    int         fails = 0;
    int         n_tests = 0;
    int         cyc = 0;

    // wired bus: any enabled driver pulls its line low
    assign bus_w = ~(d_oe & ~d_o) & ~p_oe;

    ibl_top #(.IFC_CYC(IFC)) ibl_top_i (
        .clk(clk), .nrst(nrst), .bus_i(bus_w), .bus_o(d_o), .bus_oe(d_oe),
        .sys_strap(sys_strap), .my_addr(my_addr), .par_en(par_en),
        .ctrl_atn(ctrl_atn), .ifc_req(ifc_req), .ren_req(ren_req),
        .srq_req(srq_req), .pp_req(pp_req), .pp_en(pp_en),
        .pp_line(pp_line), .pp_resp(pp_resp), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_done(tx_done),
        .pp_done(pp_done), .pp_result(pp_result), .cic(cic),
        .talker(talker), .listener(listener), .remote(remote),
        .srq_seen(srq_seen));

    ibl_peer ibl_peer_i (.clk(clk), .bus(bus_w), .oe(p_oe));

    always #10 clk = ~clk;

    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            print_verdict();
        end
    end

    // received bytes; valid only after ready, data steady under valid
    always @(posedge clk) begin
        if (rx_valid) rxq.push_back(rx_byte);
        if (!bus_w.dav && prev.dav) `CHK(prev.nrfd, 1'b1)
        if (!bus_w.dav && !prev.dav) `CHK(bus_w.dio, prev.dio)
        prev <= bus_w;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // odd parity in bit 7 of a sent command
    function automatic logic [7:0] par(input logic [7:0] b);
        return {~^b[6:0], b[6:0]};
    endfunction

    task automatic do_reset(input logic strap);
        nrst = 1'b0;
        sys_strap = strap;
        step(16);
        `CHK(d_oe, ibl_bus_t'(16'h0000))
        nrst = 1'b1;
        step(2);
    endtask

    // offer one byte, then time the handshake to its end
    task automatic tx_send(input logic [7:0] b, input logic c, input logic l);
        int n = 0;
        tx_byte = '{b, c, l};
        tx_valid = 1'b1;
        do @(posedge clk); while (!tx_ready);
        #1 tx_valid = 1'b0;
        while (!tx_done && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK(n > SETTLE_CYC, 1'b1)
        step(2);
    endtask

    task automatic peer_chk(input logic [9:0] e);
        logic [9:0] g;
        g = ibl_peer_i.got.size() > 0 ? ibl_peer_i.got.pop_front() : '1;
        `CHK(g, e)
    endtask

    // own clear: line held for exactly the set count, control taken
    task automatic t_clear();
        int n = 0;
        ifc_req = 1'b1;
        ren_req = 1'b1;
        step(1);
        ifc_req = 1'b0;
        while (bus_w.ifc && n < 10) begin
            step(1);
            n++;
        end
        n = 0;
        while (!bus_w.ifc && n < 100) begin
            step(1);
            n++;
        end
        `CHK(n, IFC)
        `CHK({cic, bus_w.ren}, 2'b10)
        `CHK(remote, 1'b1)
    endtask

    // address peer and self, commands with parity, then a data message
    task automatic t_talk();
        ibl_peer_i.acc_on = 1'b1;
        ctrl_atn = 1'b1;
        step(2);
        `CHK(bus_w.atn, 1'b0)
        tx_send(8'h21, 1'b1, 1'b0);
        tx_send(8'h45, 1'b1, 1'b0);
        peer_chk({par(8'h21), 2'b10});
        peer_chk({par(8'h45), 2'b10});
        `CHK(talker, 1'b1)
        ctrl_atn = 1'b0;
        ibl_peer_i.stall = 1;
        step(3);
        `CHK(bus_w.atn, 1'b1)
        tx_send(8'h3C, 1'b0, 1'b0);
        tx_send(8'hC3, 1'b0, 1'b1);
        peer_chk({8'h3C, 2'b00});
        peer_chk({8'hC3, 2'b01});
        ibl_peer_i.acc_on = 1'b0;
    endtask

    // parallel poll run by us, peer answers on line 3
    task automatic t_poll();
        int n = 0;
        ibl_peer_i.pp_on = 1'b1;
        pp_req = 1'b1;
        step(1);
        pp_req = 1'b0;
        step(2);
        `CHK({bus_w.atn, bus_w.eoi}, 2'b00)
        while (!pp_done && n < 500) begin
            step(1);
            n++;
        end
        `CHK(pp_result, 8'h08)
        ibl_peer_i.pp_on = 1'b0;
        step(2);
    endtask

    // service request both ways, outside any handshake
    task automatic t_srq();
        ibl_peer_i.srq = 1'b1;
        step(3);
        `CHK(srq_seen, 1'b1)
        ibl_peer_i.srq = 1'b0;
        srq_req = 1'b1;
        step(3);
        `CHK(bus_w.srq, 1'b0)
        srq_req = 1'b0;
    endtask

    // not system controller: peer addresses us, sends with back-pressure
    task automatic t_listen();
        rxq.delete();
        ifc_req = 1'b1;
        rx_ready = 1'b0;
        step(IFC + 4);
        `CHK({bus_w.ifc, bus_w.ren, cic}, 3'b110)
        ifc_req = 1'b0;
        ibl_peer_i.send(8'h25, 1'b1, 1'b0);
        fork
            ibl_peer_i.send(8'h5A, 1'b0, 1'b0);
            begin
                step(SETTLE_CYC + 8);
                `CHK({bus_w.nrfd, bus_w.ndac}, 2'b00)
                rx_ready = 1'b1;
            end
        join
        ibl_peer_i.send(8'hA5, 1'b0, 1'b1);
        step(2);
        `CHK(listener, 1'b1)
        `CHK(rxq.size(), 3)
        `CHK(rxq[0], ibl_byte_t'({8'h25, 2'b10}))
        `CHK(rxq[1], ibl_byte_t'({8'h5A, 2'b00}))
        `CHK(rxq[2], ibl_byte_t'({8'hA5, 2'b01}))
    endtask

    // answer a peer's poll, then receive control from it
    task automatic t_pass();
        pp_en = 1'b1;
        pp_resp = 1'b1;
        ibl_peer_i.atn = 1'b1;
        ibl_peer_i.eoi = 1'b1;
        step(4);
        `CHK(bus_w.dio[2], 1'b0)
        ibl_peer_i.eoi = 1'b0;
        step(2);
        ibl_peer_i.send(8'h45, 1'b1, 1'b0);
        ibl_peer_i.send(CMD_TCT, 1'b1, 1'b0);
        step(1);
        ibl_peer_i.atn = 1'b0;
        step(4);
        `CHK(cic, 1'b1)
        ctrl_atn = 1'b1;
        step(3);
        `CHK(bus_w.atn, 1'b0)
        ctrl_atn = 1'b0;
    endtask

    initial begin
        nrst = 1'b0;
        sys_strap = 1'b1;
        par_en = 1'b1;
        ctrl_atn = 1'b0;
        ifc_req = 1'b0;
        ren_req = 1'b0;
        srq_req = 1'b0;
        pp_req = 1'b0;
        pp_en = 1'b0;
        pp_resp = 1'b0;
        pp_line = 3'h2;
        my_addr = 5'h05;
        tx_valid = 1'b0;
        tx_byte = '0;
        rx_ready = 1'b1;
        do_reset(1'b1);
        t_clear();
        t_talk();
        t_poll();
        t_srq();
        do_reset(1'b0);
        t_listen();
        t_pass();
        print_verdict();
    end
endmodule
